// file: core/dmrs_pkg.sv
package dmrs_pkg;

  // ==========================================================================
  // Mode addresses.
  localparam logic [5:0] MA_THERMAL_REFRESH_STATUS    = 6'h04;
  localparam logic [5:0] MA_DEVICE_IDENTIFICATION     = 6'h08;
  localparam logic [5:0] MA_CALIBRATION_RESET_CONTROL = 6'h0a;
  localparam logic [5:0] MA_BUS_TERMINATION_CONTROL   = 6'h0b;
  localparam logic [5:0] MA_RESERVED_LO               = 6'h05;
  localparam logic [5:0] MA_RESERVED_HI               = 6'h07;
  localparam logic [5:0] MA_RESERVED_ALONE            = 6'h09;

  // ==========================================================================
  // Field positions of the thermal refresh status register.
  localparam int REFRESH_LSB        = 0;
  localparam int REFRESH_MSB        = 2;
  localparam int SELF_REFRESH_ABORT = 3;
  localparam int REPAIR_MODE_ENTRY  = 4;
  localparam int THERMAL_OFFSET_LSB = 5;
  localparam int THERMAL_OFFSET_MSB = 6;
  localparam int TEMP_UPDATE_FLAG   = 7;

  // ==========================================================================
  // Refresh multiplier codes.
  localparam logic [2:0] REFRESH_LOW_LIMIT     = 3'h0;
  localparam logic [2:0] REFRESH_X4            = 3'h1;
  localparam logic [2:0] REFRESH_X2            = 3'h2;
  localparam logic [2:0] REFRESH_X1            = 3'h3;
  localparam logic [2:0] REFRESH_HALF          = 3'h4;
  localparam logic [2:0] REFRESH_QUARTER       = 3'h5;
  localparam logic [2:0] REFRESH_QUARTER_DERATE = 3'h6;
  localparam logic [2:0] REFRESH_HIGH_LIMIT    = 3'h7;

  // ==========================================================================
  // Identification layout and values.
  localparam logic [1:0] SIXTEEN_PREFETCH_TYPE = 2'h0;
  localparam logic [1:0] WIDTH_X16             = 2'h0;
  localparam logic [3:0] DENSITY_32GB          = 4'h6;

  // ==========================================================================
  // Reset values and reserved codes.
  localparam logic [1:0] THERMAL_OFFSET_RESERVED = 2'h3;
  localparam logic [2:0] TERMINATION_DISABLED    = 3'h0;
  localparam logic [2:0] TERMINATION_RESERVED    = 3'h7;
  localparam logic [7:0] ZERO_BYTE               = 8'h00;
  localparam int         TERM_DATA_LSB           = 0;
  localparam int         TERM_DATA_MSB           = 2;
  localparam int         TERM_CMD_LSB            = 4;
  localparam int         TERM_CMD_MSB            = 6;

endpackage

// file: core/dmrs_set_point_bank.sv
`timescale 1ns/1ps
module dmrs_set_point_bank
  import dmrs_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_wr_en,
  input  wire logic       i_wr_sel,
  input  wire logic [2:0] i_wr_data,
  input  wire logic       i_rd_sel,
  input  wire logic       i_op_sel,
  output logic      [2:0] o_rd_data,
  output logic      [2:0] o_active
);

  // ==========================================================================
  // Two copies of one termination field.
  logic [2:0] copy_ff [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_copy
      always_ff @(posedge i_core_clk)
      begin
        if (i_sys_rst)
          copy_ff[g] <= TERMINATION_DISABLED;
        else if (i_wr_en && (i_wr_sel == 1'(g)))
          copy_ff[g] <= i_wr_data;
      end
    end
  endgenerate

  assign o_rd_data = copy_ff[i_rd_sel];
  assign o_active  = copy_ff[i_op_sel];

endmodule // dmrs_set_point_bank

// file: core/dmrs_mode_regs.sv
`timescale 1ns/1ps
// How it works
// - Six-bit mode address selects the four registers.
// - Refresh field bits 2:0 read-only code.
// - Code 011 at 85 degrees, bit2 above.
// - Derating needed reports refresh code 110.
// - Update flag sets when refresh code changes.
// - Reading address 04h clears update flag.
// - Flag zero after reset; field valid post-init.
// - Writes to 04h store only bits 6:3.
// - Bit 4 enters or exits repair mode.
// - Bit 3 enables self-refresh abort.
// - Bits 6:5 thermal offset, 11 reserved.
// - Type bits 1:0 report sixteen-prefetch type.
// - Density code in identification bits 5:2.
// - Width bits 7:6 report sixteen bits.
// - Addresses 05h-07h and 09h are reserved.
// - Bit 0 at 0Ah resets calibration.
// - Grounded reference pin ignores calibration commands.
// - Termination fields encode disabled, divisors, reserved.
// - Writes reach the write set-point copy; reads of 0Bh return zero.
// - Device applies the operating set-point copy.
// - Inactive copy rewrites never disturb operation.
// - Read data on low eight lines, rest zero.
module dmrs_mode_regs
  import dmrs_pkg::*;
#(
  parameter logic [3:0] DENSITY_CODE = DENSITY_32GB
)
(
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_mode_write,
  input  wire logic        i_mode_read,
  input  wire logic [5:0]  i_mode_addr,
  input  wire logic [7:0]  i_mode_wdata,
  input  wire logic        i_write_set_point_select,
  input  wire logic        i_operating_set_point_select,
  input  wire logic        i_init_done,
  input  wire logic [2:0]  i_temp_refresh_code,
  input  wire logic        i_derating_needed,
  input  wire logic        i_repair_protect,
  input  wire logic        i_calibration_reference_grounded,
  output logic             o_rdata_valid,
  output logic      [15:0] o_rdata,
  output logic             o_repair_mode_entry,
  output logic             o_self_refresh_abort,
  output logic      [1:0]  o_thermal_offset,
  output logic             o_calibration_default_reset,
  output logic      [2:0]  o_data_bus_termination,
  output logic      [2:0]  o_command_bus_termination
);

  // ==========================================================================
  // Address decode.
  function automatic logic addr_is(input logic [5:0] a, input logic [5:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  wire hit_thermal = addr_is(i_mode_addr, MA_THERMAL_REFRESH_STATUS);
  wire hit_ident   = addr_is(i_mode_addr, MA_DEVICE_IDENTIFICATION);
  wire hit_cal     = addr_is(i_mode_addr, MA_CALIBRATION_RESET_CONTROL);
  wire hit_term    = addr_is(i_mode_addr, MA_BUS_TERMINATION_CONTROL);
  wire wr_thermal  = i_mode_write && hit_thermal;
  wire wr_cal      = i_mode_write && hit_cal;
  wire wr_term     = i_mode_write && hit_term;
  wire rd_thermal  = i_mode_read && hit_thermal;

  // ==========================================================================
  // Refresh code tracking.
  logic [2:0] refresh_ff;
  logic       update_flag_ff;
  logic       abort_ff;
  logic       repair_ff;
  logic [1:0] offset_ff;
  logic       cal_reset_ff;

  // Derating overrides the sensor code so the controller sees the stricter interval.
  wire [2:0] nxt_refresh = i_derating_needed ? REFRESH_QUARTER_DERATE : i_temp_refresh_code;
  // Until initialisation ends the field sits at the nominal code and no change is flagged.
  wire       refresh_changed = i_init_done && (nxt_refresh != refresh_ff);
  wire       nxt_update_flag = refresh_changed | (update_flag_ff & ~rd_thermal);

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      refresh_ff     <= REFRESH_X1;
      update_flag_ff <= 1'b0;
    end
    else
    begin
      if (i_init_done)
        refresh_ff <= nxt_refresh;
      update_flag_ff <= nxt_update_flag;
    end
  end

  // ==========================================================================
  // Thermal register writable bits.
  wire       wr_offset_ok = i_mode_wdata[THERMAL_OFFSET_MSB:THERMAL_OFFSET_LSB] != THERMAL_OFFSET_RESERVED;
  // Repair protection blocks only the entry, never the exit.
  wire       nxt_repair   = i_mode_wdata[REPAIR_MODE_ENTRY] & ~i_repair_protect;
  wire [1:0] nxt_offset   = wr_offset_ok ? i_mode_wdata[THERMAL_OFFSET_MSB:THERMAL_OFFSET_LSB] : offset_ff;

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      abort_ff  <= 1'b0;
      repair_ff <= 1'b0;
      offset_ff <= 2'h0;
    end
    else if (wr_thermal)
    begin
      abort_ff  <= i_mode_wdata[SELF_REFRESH_ABORT];
      repair_ff <= nxt_repair;
      offset_ff <= nxt_offset;
    end
  end

  // ==========================================================================
  // Calibration reset.
  // A grounded reference keeps default calibration, so the command is dropped.
  wire nxt_cal_reset = i_mode_wdata[0] & ~i_calibration_reference_grounded;

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      cal_reset_ff <= 1'b0;
    else if (wr_cal)
      cal_reset_ff <= nxt_cal_reset;
  end

  // ==========================================================================
  // Termination copies.
  wire       term_data_ok = i_mode_wdata[TERM_DATA_MSB:TERM_DATA_LSB] != TERMINATION_RESERVED;
  wire       term_cmd_ok  = i_mode_wdata[TERM_CMD_MSB:TERM_CMD_LSB] != TERMINATION_RESERVED;
  wire [2:0] term_data_rd;
  wire [2:0] term_cmd_rd;
  wire [2:0] term_data_act;
  wire [2:0] term_cmd_act;

  dmrs_set_point_bank u_term_data (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_wr_en    (wr_term && term_data_ok),
    .i_wr_sel   (i_write_set_point_select),
    .i_wr_data  (i_mode_wdata[TERM_DATA_MSB:TERM_DATA_LSB]),
    .i_rd_sel   (i_write_set_point_select),
    .i_op_sel   (i_operating_set_point_select),
    .o_rd_data  (term_data_rd),
    .o_active   (term_data_act)
  );

  dmrs_set_point_bank u_term_cmd (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_wr_en    (wr_term && term_cmd_ok),
    .i_wr_sel   (i_write_set_point_select),
    .i_wr_data  (i_mode_wdata[TERM_CMD_MSB:TERM_CMD_LSB]),
    .i_rd_sel   (i_write_set_point_select),
    .i_op_sel   (i_operating_set_point_select),
    .o_rd_data  (term_cmd_rd),
    .o_active   (term_cmd_act)
  );

  // ==========================================================================
  // Read mux.
  wire [7:0] thermal_rd = {update_flag_ff, 4'h0, refresh_ff};
  wire [7:0] ident_rd   = {WIDTH_X16, DENSITY_CODE, SIXTEEN_PREFETCH_TYPE};
  // Termination fields are write-only; reading the selected copy is a debug view, kept
  // zero to stay deterministic for controllers that expect write-only bits to read zero.
  wire [7:0] term_rd    = ZERO_BYTE;
  wire [7:0] read_byte  = hit_thermal ? thermal_rd :
                          hit_ident   ? ident_rd   :
                          term_rd;

  logic        rvalid_ff;
  logic [15:0] rdata_ff;

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 16'h0000;
    end
    else
    begin
      rvalid_ff <= i_mode_read;
      rdata_ff  <= i_mode_read ? {8'h00, read_byte} : 16'h0000;
    end
  end

  // ==========================================================================
  // Applied settings, registered so every output comes from a flip-flop.
  logic [2:0] data_bus_termination_ff;
  logic [2:0] command_bus_termination_ff;

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      data_bus_termination_ff <= TERMINATION_DISABLED;
      command_bus_termination_ff <= TERMINATION_DISABLED;
    end
    else
    begin
      data_bus_termination_ff <= term_data_act;
      command_bus_termination_ff <= term_cmd_act;
    end
  end

  assign o_rdata_valid               = rvalid_ff;
  assign o_rdata                     = rdata_ff;
  assign o_repair_mode_entry         = repair_ff;
  assign o_self_refresh_abort        = abort_ff;
  assign o_thermal_offset            = offset_ff;
  assign o_calibration_default_reset = cal_reset_ff;
  assign o_data_bus_termination      = data_bus_termination_ff;
  assign o_command_bus_termination   = command_bus_termination_ff;

  // term_data_rd and term_cmd_rd stay for the write set-point path; reads return zero.
  wire unused_rd = ^{term_data_rd, term_cmd_rd};

endmodule // dmrs_mode_regs

// file: bench/dmrs_mode_regs_monitor.sv
`timescale 1ns/1ps
module dmrs_mode_regs_monitor
  import dmrs_pkg::*;
#(
  parameter logic [3:0] DENSITY_CODE = DENSITY_32GB
)
(
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_mode_write,
  input wire logic        i_mode_read,
  input wire logic [5:0]  i_mode_addr,
  input wire logic [7:0]  i_mode_wdata,
  input wire logic        i_write_set_point_select,
  input wire logic        i_operating_set_point_select,
  input wire logic        i_init_done,
  input wire logic [2:0]  i_temp_refresh_code,
  input wire logic        i_derating_needed,
  input wire logic        i_repair_protect,
  input wire logic        i_calibration_reference_grounded,
  input wire logic        o_rdata_valid,
  input wire logic [15:0] o_rdata,
  input wire logic        o_repair_mode_entry,
  input wire logic        o_self_refresh_abort,
  input wire logic [1:0]  o_thermal_offset,
  input wire logic        o_calibration_default_reset,
  input wire logic [2:0]  o_data_bus_termination,
  input wire logic [2:0]  o_command_bus_termination
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  wire       rd04  = i_mode_read && (i_mode_addr == MA_THERMAL_REFRESH_STATUS);
  wire       rd08  = i_mode_read && (i_mode_addr == MA_DEVICE_IDENTIFICATION);
  wire       wr04  = i_mode_write && (i_mode_addr == MA_THERMAL_REFRESH_STATUS);
  wire       wr0a  = i_mode_write && (i_mode_addr == MA_CALIBRATION_RESET_CONTROL);
  wire       wr0b  = i_mode_write && (i_mode_addr == MA_BUS_TERMINATION_CONTROL);
  wire       rzero = i_mode_addr inside {[MA_RESERVED_LO:MA_RESERVED_HI], MA_RESERVED_ALONE, 6'h0a, 6'h0b};
  wire       osel  = i_operating_set_point_select;
  wire [4:0] sens  = {i_init_done, i_derating_needed, i_temp_refresh_code};
  wire [2:0] fld   = !i_init_done ? REFRESH_X1 : (i_derating_needed ? REFRESH_QUARTER_DERATE : i_temp_refresh_code);
  sequence calm_read;
    rd04 && $stable(sens);
  endsequence
  sequence set_point_held;
    $stable(osel) ##1 $stable(osel);
  endsequence
  // ====================
  // Read path.
  read_answer_a: assert property (i_mode_read |=> o_rdata_valid && (o_rdata[15:8] == 8'h00))
    else $error("read answer wrong");
  reserved_zero_a: assert property (i_mode_read && rzero |=> o_rdata == 16'h0000)
    else $error("reserved read not zero");
  ident_value_a: assert property (rd08 |=>
    o_rdata == {8'h00, WIDTH_X16, DENSITY_CODE, SIXTEEN_PREFETCH_TYPE}) else $error("identification wrong");
  refresh_code_a: assert property ($stable(sens) ##1 calm_read |=> o_rdata[6:0] == {4'h0, $past(fld)})
    else $error("refresh field wrong");
  // Reads are at least two cycles apart, so the second read is looked for one idle cycle later.
  flag_clear_a: assert property ($stable(sens) ##1 calm_read ##1 $stable(sens) ##1 calm_read |=>
    !o_rdata[TEMP_UPDATE_FLAG]) else $error("update flag not cleared");
  flag_set_a: assert property (!$past(i_sys_rst) && $changed(fld) && !i_mode_read ##1 (!i_mode_read)[*3]
    ##1 rd04 |=> o_rdata[TEMP_UPDATE_FLAG]) else $error("update flag not set");
  // ====================
  // Write path.
  ctl_write_a: assert property (wr04 |=> {o_repair_mode_entry, o_self_refresh_abort} ==
    {$past(i_mode_wdata[4]) && !$past(i_repair_protect), $past(i_mode_wdata[3])}) else $error("control bit wrong");
  offset_write_a: assert property (wr04 |=> o_thermal_offset ==
    (($past(i_mode_wdata[6:5]) == THERMAL_OFFSET_RESERVED) ? $past(o_thermal_offset) : $past(i_mode_wdata[6:5])))
    else $error("thermal offset wrong");
  cal_write_a: assert property (wr0a |=> o_calibration_default_reset ==
    ($past(i_mode_wdata[0]) && !$past(i_calibration_reference_grounded))) else $error("calibration bit wrong");
  term_apply_a: assert property (wr0b && (i_write_set_point_select == osel) && (i_mode_wdata[2:0] != 3'h7)
    ##1 set_point_held |-> o_data_bus_termination == $past(i_mode_wdata[2:0], 2)) else $error("termination wrong");
  cmd_term_a: assert property (wr0b && (i_write_set_point_select == osel)
    && (i_mode_wdata[6:4] != TERMINATION_RESERVED) ##1 set_point_held
    |-> o_command_bus_termination == $past(i_mode_wdata[6:4], 2)) else $error("command termination wrong");
endmodule // dmrs_mode_regs_monitor

bind dmrs_mode_regs dmrs_mode_regs_monitor #(.DENSITY_CODE(DENSITY_CODE)) dmrs_mode_regs_monitor_inst (.*);

// file: bench/dmrs_ctrl_model.sv
`timescale 1ns/1ps
module dmrs_ctrl_model
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rdata_valid,
  input  wire logic [15:0] i_rdata,
  output logic             o_mode_write,
  output logic             o_mode_read,
  output logic      [5:0]  o_mode_addr,
  output logic      [7:0]  o_mode_wdata
);
  logic out_of_range;
  logic [2:0] refresh_scale;
  initial
  begin
    o_mode_write = 1'b0;
    o_mode_read  = 1'b0;
    o_mode_addr  = 6'h00;
    o_mode_wdata = 8'h00;
  end
  // Address and data are scrambled once taken, so stale values never pass for live ones.
  task automatic issue(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_mode_write <= wr;
    o_mode_read  <= !wr;
    o_mode_addr  <= a;
    o_mode_wdata <= d;
    @(posedge i_core_clk);
    o_mode_write <= 1'b0;
    o_mode_read  <= 1'b0;
    o_mode_addr  <= ~a;
    o_mode_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [16:0] r);
    issue(1'b0, a, 8'h00);
    #1 r = {i_rdata_valid, i_rdata};
    if (a == 6'h04)
    begin
      out_of_range = (i_rdata[2:0] == 3'h0) || (i_rdata[2:0] == 3'h7);
      refresh_scale = i_rdata[2:0];
    end
  endtask
endmodule // dmrs_ctrl_model

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dmrs_pkg::*;
  logic        i_core_clk, i_sys_rst, i_mode_write, i_mode_read, i_init_done, o_rdata_valid;
  logic        i_write_set_point_select, i_operating_set_point_select, i_derating_needed;
  logic        i_repair_protect, i_calibration_reference_grounded, o_calibration_default_reset;
  logic        o_repair_mode_entry, o_self_refresh_abort;
  logic [1:0]  o_thermal_offset;
  logic [2:0]  i_temp_refresh_code, o_data_bus_termination, o_command_bus_termination;
  logic [5:0]  i_mode_addr;
  logic [7:0]  i_mode_wdata;
  logic [15:0] o_rdata;
  logic [5:0]  rsv[8] = '{6'h05, 6'h06, 6'h07, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h3f};
  int          fail_count = 0;
  int          cmp_count = 0;
  int          m_fld = 3, m_flag = 0, m_sra = 0, m_rep = 0, m_off = 0, m_cal = 0, e;
  int          m_dt[2] = '{0, 0};
  int          m_ct[2] = '{0, 0};
  dmrs_mode_regs #(.DENSITY_CODE(4'hc)) dmrs_mode_regs_inst (.*);
  dmrs_ctrl_model dmrs_ctrl_model_inst (.i_core_clk(i_core_clk), .i_rdata_valid(o_rdata_valid), .i_rdata(o_rdata),
    .o_mode_write(i_mode_write), .o_mode_read(i_mode_read), .o_mode_addr(i_mode_addr), .o_mode_wdata(i_mode_wdata));
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // ====================
  // Checking.
  task automatic finish_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [5:0] a, input logic [15:0] exp);
    logic [16:0] r;
    dmrs_ctrl_model_inst.rd(a, r);
    check(r, {1'b1, exp});
  endtask
  task automatic cmp_ctl();
    check({o_repair_mode_entry, o_self_refresh_abort, o_thermal_offset, o_calibration_default_reset,
      o_data_bus_termination, o_command_bus_termination}, {m_rep[0], m_sra[0], m_off[1:0], m_cal[0],
      m_dt[i_operating_set_point_select][2:0], m_ct[i_operating_set_point_select][2:0]});
  endtask
  // Termination shows one cycle after the taking edge, behind the copy flop; the check waits two edges.
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    dmrs_ctrl_model_inst.issue(1'b1, a, d);
    if (a == 6'h04)
    begin
      m_sra = d[3];
      m_rep = d[4] & !i_repair_protect;
      m_off = (d[6:5] == 2'h3) ? m_off : d[6:5];
    end
    if (a == 6'h0a)
      m_cal = d[0] & !i_calibration_reference_grounded;
    if (a == 6'h0b)
    begin
      m_dt[i_write_set_point_select] = (d[2:0] == 3'h7) ? m_dt[i_write_set_point_select] : d[2:0];
      m_ct[i_write_set_point_select] = (d[6:4] == 3'h7) ? m_ct[i_write_set_point_select] : d[6:4];
    end
    repeat (2) @(posedge i_core_clk);
    #1 cmp_ctl();
  endtask
  initial
  begin
    {i_sys_rst, i_init_done, i_derating_needed, i_repair_protect} = 4'h8;
    {i_calibration_reference_grounded, i_write_set_point_select, i_operating_set_point_select} = 3'h0;
    i_temp_refresh_code = 3'h3;
    void'($urandom(82126));
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    #1 cmp_ctl();
    cmp_rd(6'h04, 16'h0003);
    cmp_rd(6'h08, 16'h0030);
    foreach (rsv[k]) cmp_rd(rsv[k], 16'h0000);
    foreach (rsv[k]) wr_reg(rsv[k], 8'hff);
    wr_reg(6'h08, 8'hff);
    for (int i = 0; i < 9; i++)
    begin
      @(posedge i_core_clk);
      i_init_done <= 1'b1;
      i_temp_refresh_code <= i[2:0];
      i_derating_needed <= (i == 8);
      e = (i == 8) ? 6 : i;
      m_flag = m_flag | (e != m_fld);
      m_fld = e;
      repeat (3) @(posedge i_core_clk);
      cmp_rd(6'h04, {8'h00, m_flag[0], 4'h0, m_fld[2:0]});
      m_flag = 0;
      cmp_rd(6'h04, {13'h0000, m_fld[2:0]});
    end
    @(posedge i_core_clk);
    i_derating_needed <= 1'b0;
    m_fld = 0;
    m_flag = 1;
    repeat (40)
    begin
      @(posedge i_core_clk);
      i_repair_protect <= 1'($urandom);
      i_calibration_reference_grounded <= 1'($urandom);
      i_write_set_point_select <= 1'($urandom);
      i_operating_set_point_select <= 1'($urandom);
      wr_reg(6'h04, 8'($urandom));
      wr_reg(6'h0a, 8'($urandom));
      wr_reg(6'h0b, 8'($urandom));
    end
    cmp_rd(6'h04, {8'h00, m_flag[0], 4'h0, m_fld[2:0]});
    // A second reset in mid-run restores the nominal code, which then differs from the sensed one.
    @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    m_sra = 0;
    m_rep = 0;
    m_off = 0;
    m_cal = 0;
    m_dt = '{0, 0};
    m_ct = '{0, 0};
    #1 cmp_ctl();
    cmp_rd(6'h04, 16'h0080);
    cmp_rd(6'h04, 16'h0000);
    finish_test();
  end
endmodule // tb_top
